/* File: hdl/btl_defines.svh */
// Timing, width and reset constants of the sixteen-channel biphase link.
// Assumes a 100 MHz system clock; counts are derived from the times below.
`ifndef BTL_DEFINES_SVH
`define BTL_DEFINES_SVH

`define BTL_CHANNELS    16
`define BTL_CLK_NS      10
`define BTL_SHORT_NS    143
`define BTL_LONG_NS     286
`define BTL_SAMPLE_NS   5000

// Pulse widths are nominal, so they round to the nearest cycle
`define BTL_SHORT_CYC   ((`BTL_SHORT_NS + `BTL_CLK_NS / 2) / `BTL_CLK_NS)
`define BTL_LONG_CYC    ((`BTL_LONG_NS + `BTL_CLK_NS / 2) / `BTL_CLK_NS)
`define BTL_SAMPLE_CYC  (`BTL_SAMPLE_NS / `BTL_CLK_NS)

`define BTL_LINE_RST    1'b0
`define BTL_WORD_RST    16'h0000

`endif

/* File: hdl/btl_pkg.sv */
// Types shared by the biphase link encoder and decoder.
// Assumes nothing of its surroundings.
package btl_pkg;

   typedef enum logic [2:0] {
      ENC_SYNC1,
      ENC_SYNC2,
      ENC_HI1,
      ENC_HI2,
      ENC_LO
   } btl_enc_st_t;

   typedef struct packed {
      logic valid;
      logic sync;
      logic data;
      logic err;
   } btl_sym_t;

endpackage

/* File: hdl/btl_decoder.sv */
// Biphase pulse classifier: turns line transitions into data and sync symbols.
// Assumes ser_i is synchronous to clk_i.
`timescale 1ns/1ns
`include "btl_defines.svh"
module btl_decoder
   import btl_pkg::*;
#(
   parameter int SHORT_CYC = `BTL_SHORT_CYC,
   parameter int LONG_CYC  = `BTL_LONG_CYC
) (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic ser_i,
   output btl_sym_t  sym_o
);

   localparam int MID_CYC = (SHORT_CYC + LONG_CYC) / 2;
   localparam int MAX_CYC = SHORT_CYC + LONG_CYC;
   localparam int RW      = $clog2(MAX_CYC + 2);

   logic          prev_r;
   logic [RW-1:0] run_r;
   logic          pend_r;
   logic          pend_nxt;
   btl_sym_t      sym_r;
   btl_sym_t      sym_nxt;
   wire           edge_w;
   wire           is_short;
   wire           is_long;
   wire           run_sat;

   assign edge_w   = ser_i ^ prev_r;
   assign is_short = run_r <= RW'(MID_CYC);
   assign is_long  = !is_short && (run_r <= RW'(MAX_CYC));
   assign run_sat  = run_r == RW'(MAX_CYC + 1);

   // Short then short is a one, long alone a zero, short then long is sync
   assign sym_nxt  = '{valid: edge_w && (is_long || (is_short && pend_r)),
                       sync:  is_long && pend_r,
                       data:  is_short,
                       err:   edge_w && !is_short && !is_long};
   assign pend_nxt = edge_w ? (is_short && !pend_r) : pend_r;
   assign sym_o    = sym_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_r <= `BTL_LINE_RST;
         run_r  <= '0;
         pend_r <= 1'b0;
         sym_r  <= '0;
      end else begin
         prev_r <= ser_i;
         run_r  <= edge_w ? RW'(1) : (run_sat ? run_r : run_r + RW'(1));
         pend_r <= pend_nxt;
         sym_r  <= sym_nxt;
      end
   end

   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   a_dec_one_pair: assert property (edge_w && is_short && pend_r
      |=> sym_o.valid && sym_o.data && !sym_o.sync)
      else $error("two short pulses not decoded as one");
   a_dec_sync_sym: assert property (edge_w && is_long && pend_r
      |=> sym_o.valid && sym_o.sync ##1 !pend_r)
      else $error("short-long not decoded as sync");
   a_dec_edge_only: assert property (sym_o.valid |-> $past(edge_w))
      else $error("symbol decoded without a transition");

endmodule // btl_decoder

/* File: hdl/btl_link.sv */
// Sixteen-channel sampled biphase link: sampler, encoder, loopback selectors,
// receive shift register, output latch and carrier indicator.
// Assumes all inputs synchronous to clk_i; the far end is an identical unit.
`timescale 1ns/1ns
`include "btl_defines.svh"
module btl_link
   import btl_pkg::*;
#(
   parameter int CHANNELS   = `BTL_CHANNELS,
   parameter int SHORT_CYC  = `BTL_SHORT_CYC,
   parameter int LONG_CYC   = `BTL_LONG_CYC,
   parameter int SAMPLE_CYC = `BTL_SAMPLE_CYC
) (
   input  wire logic                clk_i,
   input  wire logic                arst_n_i,
   input  wire logic [CHANNELS-1:0] chan_in_i,
   input  wire logic                loop_test_i,
   input  wire logic                opt_rx_i,
   output logic                     opt_tx_o,
   output logic [CHANNELS-1:0]      chan_out_o,
   output logic                     carrier_o,
   output logic                     frame_stb_o
);

   localparam int SW   = $clog2(SAMPLE_CYC);
   localparam int PW_W = $clog2(LONG_CYC + 1);
   localparam int CW   = $clog2(CHANNELS + 2);

   // Width of the pulse that a state puts on the line
   function automatic logic [PW_W-1:0] width_of(input btl_enc_st_t st);
      width_of = (st == ENC_SYNC2 || st == ENC_LO) ? PW_W'(LONG_CYC) : PW_W'(SHORT_CYC);
   endfunction

   // ---------------- Sampler ----------------
   logic [SW-1:0]       samp_cnt_r;
   logic [CHANNELS-1:0] snap_r;
   wire                 samp_en;

   assign samp_en = samp_cnt_r == SW'(SAMPLE_CYC - 1);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         samp_cnt_r <= '0;
         snap_r     <= `BTL_WORD_RST;
      end else begin
         samp_cnt_r <= samp_en ? '0 : samp_cnt_r + SW'(1);
         if (samp_en) begin
            snap_r <= chan_in_i;
         end
      end
   end

   // ---------------- Encoder ----------------
   // Frames run back to back and each takes the latest sample, so a sample
   // may be sent twice but all channels always travel in the same frame.
   btl_enc_st_t         st_r;
   btl_enc_st_t         st_nxt;
   logic [PW_W-1:0]     pw_r;
   logic [CHANNELS-1:0] tx_sr_r;
   logic [CW-1:0]       tx_cnt_r;
   logic                enc_line_r;
   wire                 pend;
   wire                 last_sym;
   wire                 sym_done;
   wire                 frame_start;

   assign pend        = pw_r == PW_W'(1);
   assign last_sym    = tx_cnt_r == CW'(CHANNELS - 1);
   assign sym_done    = pend && (st_r == ENC_HI2 || st_r == ENC_LO);
   assign frame_start = pend && st_nxt == ENC_SYNC1;

   // A one is HI1 then HI2, a zero is LO alone; sixteen of them follow sync
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ENC_SYNC1: begin
            st_nxt = ENC_SYNC2;
         end
         ENC_SYNC2: begin
            st_nxt = tx_sr_r[0] ? ENC_HI1 : ENC_LO;
         end
         ENC_HI1: begin
            st_nxt = ENC_HI2;
         end
         default: begin
            st_nxt = last_sym ? ENC_SYNC1 : (tx_sr_r[1] ? ENC_HI1 : ENC_LO);
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r       <= ENC_SYNC1;
         pw_r       <= PW_W'(SHORT_CYC);
         enc_line_r <= `BTL_LINE_RST;
      end else if (pend) begin
         st_r       <= st_nxt;
         pw_r       <= width_of(st_nxt);
         enc_line_r <= ~enc_line_r;
      end else begin
         pw_r       <= pw_r - PW_W'(1);
      end
   end

   // Channel 0 goes first after sync
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_sr_r  <= `BTL_WORD_RST;
         tx_cnt_r <= '0;
      end else if (frame_start) begin
         tx_sr_r  <= snap_r;
         tx_cnt_r <= '0;
      end else if (sym_done) begin
         tx_sr_r  <= tx_sr_r >> 1;
         tx_cnt_r <= tx_cnt_r + CW'(1);
      end
   end

   // ---------------- Loopback selectors ----------------
   logic opt_tx_r;
   wire  dec_in;

   assign dec_in = loop_test_i ? enc_line_r : opt_rx_i;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         opt_tx_r <= `BTL_LINE_RST;
      end else begin
         opt_tx_r <= loop_test_i ? opt_rx_i : enc_line_r;
      end
   end

   // ---------------- Decoder and output latch ----------------
   btl_sym_t            sym;
   logic [CHANNELS-1:0] rx_sr_r;
   logic [CW-1:0]       rx_cnt_r;
   logic [CHANNELS-1:0] chan_out_r;
   logic                frame_stb_r;
   wire                 latch_go;
   wire                 rx_data;

   // Both paths live in this unit so two units form a duplex pair
   btl_decoder #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
   ) u_dec (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .ser_i    (dec_in),
      .sym_o    (sym)
   );

   assign latch_go = sym.valid && sym.sync && rx_cnt_r == CW'(CHANNELS);
   assign rx_data  = sym.valid && !sym.sync;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_sr_r  <= `BTL_WORD_RST;
         rx_cnt_r <= CW'(CHANNELS + 1);
      end else if (sym.err) begin
         rx_cnt_r <= CW'(CHANNELS + 1);
      end else if (sym.valid && sym.sync) begin
         rx_cnt_r <= '0;
      end else if (rx_data) begin
         rx_sr_r  <= {sym.data, rx_sr_r[CHANNELS-1:1]};
         if (rx_cnt_r != CW'(CHANNELS + 1)) begin
            rx_cnt_r <= rx_cnt_r + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan_out_r  <= `BTL_WORD_RST;
         frame_stb_r <= 1'b0;
      end else begin
         frame_stb_r <= latch_go;
         if (latch_go) begin
            chan_out_r <= rx_sr_r;
         end
      end
   end

   // ---------------- Carrier indicator ----------------
   logic rx_prev_r;
   logic carrier_r;
   wire  rx_edge;
   wire  carrier_nxt;

   assign rx_edge     = opt_rx_i ^ rx_prev_r;
   // A transition in the clearing cycle keeps the indicator on
   assign carrier_nxt = loop_test_i ? 1'b0 : (rx_edge ? 1'b1 : (samp_en ? 1'b0 : carrier_r));

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_prev_r <= `BTL_LINE_RST;
         carrier_r <= 1'b0;
      end else begin
         rx_prev_r <= opt_rx_i;
         carrier_r <= carrier_nxt;
      end
   end

   assign opt_tx_o    = opt_tx_r;
   assign chan_out_o  = chan_out_r;
   assign carrier_o   = carrier_r;
   assign frame_stb_o = frame_stb_r;

   // ---------------- Checks ----------------
   logic [SW:0]   h_gap_r;
   logic [PW_W:0] h_run_r;
   logic [CW-1:0] h_sym_r;
   logic          h_frm_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         h_gap_r <= '0;
         h_run_r <= (PW_W+1)'(1);
      end else begin
         h_gap_r <= samp_en ? '0 : h_gap_r + (SW+1)'(1);
         h_run_r <= pend ? (PW_W+1)'(1) : h_run_r + (PW_W+1)'(1);
      end
   end

   // Counts data symbols between sync shorts, apart from tx_cnt_r
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         h_sym_r <= '0;
         h_frm_r <= 1'b0;
      end else if (pend && st_r == ENC_SYNC1) begin
         h_sym_r <= '0;
         h_frm_r <= 1'b1;
      end else if (sym_done) begin
         h_sym_r <= h_sym_r + CW'(1);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_sync_short;
      pend && st_r == ENC_SYNC1;
   endsequence

   sequence s_sync_long;
      (st_r == ENC_SYNC2 && pw_r == PW_W'(LONG_CYC)) ##1 (st_r == ENC_SYNC2)[*7];
   endsequence

   sequence s_hi_first;
      pend && st_r == ENC_HI1;
   endsequence

   sequence s_hi_second;
      (st_r == ENC_HI2 && pw_r == PW_W'(SHORT_CYC)) ##1 (st_r == ENC_HI2)[*3];
   endsequence

   // Repetition counts suit pulse widths down to four and eight cycles
   a_sample_period: assert property (samp_en |-> h_gap_r == (SW+1)'(SAMPLE_CYC - 1))
      else $error("sample strobe period wrong");
   a_sample_capture: assert property (samp_en |=> snap_r == $past(chan_in_i))
      else $error("inputs not captured together");
   a_pulse_width: assert property (pend |-> h_run_r == (PW_W+1)'(SHORT_CYC)
      || h_run_r == (PW_W+1)'(LONG_CYC))
      else $error("line pulse neither short nor long");
   a_high_pair: assert property (s_hi_first |=> s_hi_second)
      else $error("high level not sent as two shorts");
   a_sync_symbol: assert property (s_sync_short |=> s_sync_long)
      else $error("sync short not followed by long");
   a_frame_length: assert property (pend && st_r == ENC_SYNC1 && h_frm_r
      |-> h_sym_r == CW'(CHANNELS))
      else $error("frame does not carry sixteen symbols");
   a_frame_reload: assert property (frame_start |=> tx_sr_r == $past(snap_r))
      else $error("frame not loaded from one sample");
   a_rx_shift: assert property (rx_data && !sym.err
      |=> rx_sr_r[CHANNELS-1] == $past(sym.data))
      else $error("decoded bit not shifted in");
   a_latch_sync: assert property (latch_go |=> chan_out_o == $past(rx_sr_r) && frame_stb_o)
      else $error("outputs not loaded on sync");
   a_latch_hold: assert property (!latch_go |=> $stable(chan_out_o) && !frame_stb_o)
      else $error("outputs changed without valid sync");
   a_stb_pulse: assert property (frame_stb_o |=> !frame_stb_o)
      else $error("frame strobe longer than one cycle");
   a_rx_err_drop: assert property (sym.err |=> rx_cnt_r == CW'(CHANNELS + 1))
      else $error("decode error did not void the frame");
   a_rx_sync_arm: assert property (sym.valid && sym.sync |=> rx_cnt_r == CW'(0))
      else $error("sync did not restart symbol count");
   a_carrier_clear: assert property (samp_en && !rx_edge |=> !carrier_o)
      else $error("carrier not cleared at sample tick");
   a_carrier_set: assert property (rx_edge && !loop_test_i |=> carrier_o)
      else $error("carrier not set by transition");
   a_carrier_test: assert property (loop_test_i |=> !carrier_o)
      else $error("carrier shown in test position");
   a_loop_test: assert property (loop_test_i |=> opt_tx_o == $past(opt_rx_i))
      else $error("test position does not echo receiver");
   a_loop_run: assert property (!loop_test_i |=> opt_tx_o == $past(enc_line_r))
      else $error("run position does not send encoder");

endmodule // btl_link

/* File: sim/btl_far_end.sv */
// Far-end unit model: sends biphase frames of a held word on its line.
// Assumes the bench holds word_i steady over whole frames.
`timescale 1ns/1ns
module btl_far_end #(
   parameter int S = 4,
   parameter int L = 8
) (
   input  wire logic        clk_i,
   input  wire logic        en_i,
   input  wire logic        skip_i,
   input  wire logic [15:0] word_i,
   output logic             line_o
);
   initial line_o = 1'b0;
   task automatic pulse(input int n);
      repeat (n) @(posedge clk_i);
      line_o <= ~line_o;
   endtask
   // Line stands still between frames while disabled
   always begin
      if (!en_i) begin
         @(posedge clk_i);
      end else begin
         pulse(S);
         pulse(L);
         for (int k = 0; k < (skip_i ? 15 : 16); k++) begin
            if (word_i[k]) begin
               pulse(S);
               pulse(S);
            end else begin
               pulse(L);
            end
         end
      end
   end
endmodule // btl_far_end

/* File: sim/btl_link_bench.sv */
// Self-checking bench of the biphase link with a far-end model.
// Assumes shortened pulse and sample counts; wrap_r models a fiber loop.
`timescale 1ns/1ns
module btl_link_bench;
   import btl_pkg::*;
   localparam int SC = 4;
   localparam int LC = 8;
   localparam int SP = 100;
   logic        clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic [15:0] chan_in_i = 16'h0000;
   logic        loop_test_i = 1'b0;
   logic        opt_tx_o, carrier_o, frame_stb_o, far_line, en_r, skip_r, wrap_r, prev_rx;
   logic [15:0] chan_out_o, word_r;
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;
   wire logic   opt_rx_i = wrap_r ? opt_tx_o : far_line;

   btl_link #(.SHORT_CYC(SC), .LONG_CYC(LC), .SAMPLE_CYC(SP)) i_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .chan_in_i(chan_in_i), .loop_test_i(loop_test_i),
      .opt_rx_i(opt_rx_i), .opt_tx_o(opt_tx_o), .chan_out_o(chan_out_o),
      .carrier_o(carrier_o), .frame_stb_o(frame_stb_o));
   btl_far_end #(.S(SC), .L(LC)) i_far (
      .clk_i(clk_i), .en_i(en_r), .skip_i(skip_r), .word_i(word_r), .line_o(far_line));

   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %b", $time, m, got);
      end
   endtask
   // Returns on the negedge holding the strobe, or after 401 negedges, then checks the strobe is there
   task automatic wait_stb();
      int n;
      n = 0;
      @(negedge clk_i);
      while (frame_stb_o !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      chk_bit(frame_stb_o, 1'b1, "strobe missing");
   endtask
   task automatic stb_gone();
      @(negedge clk_i);
      chk_bit(frame_stb_o, 1'b0, "strobe too long");
   endtask

   task automatic t_receive(input logic [15:0] w);
      int n;
      @(posedge clk_i);
      word_r <= w;
      repeat (3) wait_stb();
      chk_word(chan_out_o, w, "received word");
      stb_gone();
      // Judge carrier one cycle after a line transition, so a clearing tick cannot hide it
      n = 0;
      prev_rx = opt_rx_i;
      @(negedge clk_i);
      while (opt_rx_i === prev_rx && n < 2 * LC) begin
         @(negedge clk_i);
         n++;
      end
      @(negedge clk_i);
      chk_bit(carrier_o, 1'b1, "carrier off");
   endtask
   task automatic t_short_frame();
      logic [15:0] held;
      held = chan_out_o;
      @(posedge clk_i);
      skip_r <= 1'b1;
      word_r <= ~held;
      repeat (450) begin
         @(negedge clk_i);
         chk_bit(frame_stb_o, 1'b0, "load on short frame");
      end
      chk_word(chan_out_o, held, "latch moved");
      @(posedge clk_i);
      skip_r <= 1'b0;
   endtask
   task automatic t_carrier();
      @(posedge clk_i);
      en_r <= 1'b0;
      repeat (400) @(negedge clk_i);
      chk_bit(carrier_o, 1'b0, "carrier not cleared");
      @(posedge clk_i);
      en_r <= 1'b1;
      repeat (SC + 3) @(negedge clk_i);
      chk_bit(carrier_o, 1'b1, "carrier not set");
   endtask
   task automatic t_loopback(input logic [15:0] w);
      @(posedge clk_i);
      loop_test_i <= 1'b1;
      chan_in_i <= w;
      repeat (4) wait_stb();
      chk_word(chan_out_o, w, "local loop word");
      chk_bit(carrier_o, 1'b0, "carrier in test");
      prev_rx = opt_rx_i;
      repeat (60) begin
         @(negedge clk_i);
         chk_bit(opt_tx_o, prev_rx, "rx not returned");
         prev_rx = opt_rx_i;
      end
      @(posedge clk_i);
      loop_test_i <= 1'b0;
   endtask
   task automatic t_wrap(input logic [15:0] a, input logic [15:0] b);
      @(posedge clk_i);
      wrap_r <= 1'b1;
      chan_in_i <= a;
      repeat (4) wait_stb();
      chk_word(chan_out_o, a, "wrapped word");
      @(posedge clk_i);
      chan_in_i <= b;
      repeat (4) begin
         wait_stb();
         chk_bit((chan_out_o === a) || (chan_out_o === b), 1'b1, "split word");
      end
      chk_word(chan_out_o, b, "wrapped update");
      @(posedge clk_i);
      wrap_r <= 1'b0;
   endtask

   initial begin
      en_r = 1'b1;
      skip_r = 1'b0;
      wrap_r = 1'b0;
      word_r = 16'hA5C3;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_receive(16'hA5C3);
      t_receive(16'hFFFF);
      t_receive(16'h0000);
      t_receive(16'h8001);
      t_short_frame();
      t_receive(16'h7E18);
      t_carrier();
      t_loopback(16'h3C5A);
      t_wrap(16'h9F06, 16'h60F9);
      stop_test();
   end
endmodule // btl_link_bench
